//--- hdl/rsm_reset_sleep.sv
// Functional notes
// - Power-on clears all bits, RC on, crystal off, core held reset at address zero.
// - Port A wake from sleep keeps cold-reset bits: flags, clock select, RC bias.
// - System reset clears system bits, port config if enabled, resets core.
// - Halt stops core, clocks run; reset or enabled wake request ends standby.
// - Sleep stops all circuit clocks and peripherals; no time keeping.
// - Sleep ends only by power-on, reset pin or Port A combination.
// - Control bit 7: sleep unlock, read/write, cold reset clears.
// - Control bit 6: lets port-config reset follow the global reset.
// - Control bit 5: bad address access causes reset.
// - Control bit 4: watchdog reset enable, only cold reset clears it.
// - Control bits 3..0 read zero.
// - Cause bit 7 is sleep request, always reads zero.
// - Cause bits 5..1 are read-to-clear source flags; bits 6 and 0 read zero.
// - Watchdog register: key written, counter read in bits 3..0.
// - Watchdog clears on key 0x0A directly followed by 0x03, and restarts from zero when it fires.
// - Watchdog counts 0..8, resets system on reaching 8 when enabled.
// - Any write to the cause register clears the flags.
// - Port-config reset asserts only with system reset and its enable, or at power-on.
`timescale 1ns/1ps
`default_nettype none

module rsm_reset_sleep #(
   parameter int RST_STRETCH = rsm_pkg::RST_STRETCH
) (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [rsm_pkg::ADR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [rsm_pkg::DAT_W-1:0] wb_dat_in,
   output logic [rsm_pkg::DAT_W-1:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic reset_pin_in,
   input wire logic port_combo_in,
   input wire logic bad_access_in,
   input wire logic halt_in,
   input wire logic wake_req_in,
   input wire logic wd_tick_in,
   output rsm_pkg::rsm_rst_s rst_out,
   output logic cpu_halt_out,
   output logic clk_run_out,
   output logic rc_osc_en_out,
   output logic xtal_en_out,
   output logic rc_bias_out
);

   localparam int SC_W = $clog2(RST_STRETCH + 1);

   generate
      if (RST_STRETCH < 1) begin : g_bad_stretch
         $error("rsm_reset_sleep: RST_STRETCH must be at least 1");
      end
   endgenerate

   rsm_pkg::rsm_mode_e mode_r;
   rsm_pkg::rsm_ctrl_s ctrl_r;
   logic [rsm_pkg::FL_W-1:0] flags_r;
   logic ext_sel_r;
   logic bias_r;
   logic [SC_W-1:0] stretch_r;
   logic pin_m_r;
   logic pin_s_r;
   logic combo_m_r;
   logic combo_s_r;

   logic acc;
   logic wr;
   logic mapped;
   logic hit_ctrl;
   logic hit_cause;
   logic hit_wd;
   logic hit_clk;
   logic asleep;
   logic wd_fire;
   logic bad_hit;
   logic src;
   logic sleep_go;
   logic cause_clr;
   logic [rsm_pkg::WD_W-1:0] wd_count;
   logic [rsm_pkg::FL_W-1:0] cause_set;
   logic [rsm_pkg::DAT_W-1:0] rd_nxt;

   // Pin-side inputs cross from outside the clock domain
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         pin_m_r <= 1'b0;
         pin_s_r <= 1'b0;
         combo_m_r <= 1'b0;
         combo_s_r <= 1'b0;
      end else begin
         pin_m_r <= reset_pin_in;
         pin_s_r <= pin_m_r;
         combo_m_r <= port_combo_in;
         combo_s_r <= combo_m_r;
      end
   end

   // Bus decode, one access per request
   assign acc = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign wr = acc && wb_we_in && wb_sel_in[0];
   assign hit_ctrl = (wb_adr_in == rsm_pkg::OFS_CTRL);
   assign hit_cause = (wb_adr_in == rsm_pkg::OFS_CAUSE);
   assign hit_wd = (wb_adr_in == rsm_pkg::OFS_WD);
   assign hit_clk = (wb_adr_in == rsm_pkg::OFS_CLK);
   assign mapped = hit_ctrl || hit_cause || hit_wd || hit_clk;

   assign asleep = (mode_r == rsm_pkg::MODE_SLEEP);

   // Bad access also covers holes in this register window
   assign bad_hit = ctrl_r.bad_access_reset_enable && !asleep &&
                    (bad_access_in || (acc && !mapped));

   // In sleep only the pin and Port A can start a reset
   assign src = pin_s_r || combo_s_r || (wd_fire && !asleep) || bad_hit;

   // Unlock must already be set when the request is written
   assign sleep_go = wr && hit_cause && wb_dat_in[rsm_pkg::RC_SLEEP] &&
                     ctrl_r.sleep_unlock && !src;

   assign cause_clr = acc && hit_cause;

   always_comb begin
      cause_set = '0;
      cause_set[rsm_pkg::FL_BAD] = bad_hit;
      cause_set[rsm_pkg::FL_WD] = wd_fire && !asleep;
      cause_set[rsm_pkg::FL_PORT] = combo_s_r;
      cause_set[rsm_pkg::FL_PIN] = pin_s_r;
      cause_set[rsm_pkg::FL_PIN_SLP] = pin_s_r && asleep;
   end

   rsm_watchdog #(
      .CNT_W(rsm_pkg::WD_W)
   ) u_wd (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .key_wr_in(wr && hit_wd),
      .key_in(wb_dat_in[rsm_pkg::WD_W-1:0]),
      .tick_in(wd_tick_in && !asleep),
      .enable_in(ctrl_r.watchdog_reset_enable),
      .restart_in(wd_fire),
      .count_out(wd_count),
      .fire_out(wd_fire)
   );

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         ctrl_r <= '0;
      end else if (wr && hit_ctrl) begin
         ctrl_r.sleep_unlock <= wb_dat_in[rsm_pkg::SC_UNLOCK];
         ctrl_r.port_cfg_reset_enable <= wb_dat_in[rsm_pkg::SC_PCFG];
         ctrl_r.bad_access_reset_enable <= wb_dat_in[rsm_pkg::SC_BAD];
         ctrl_r.watchdog_reset_enable <= ctrl_r.watchdog_reset_enable ||
                                         wb_dat_in[rsm_pkg::SC_WD];
      end
   end

   // A cause arriving with a clear survives it
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         flags_r <= '0;
      end else begin
         flags_r <= (cause_clr ? '0 : flags_r) | cause_set;
      end
   end

   // Cold-only bits, untouched by any system reset or Port A wake
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         ext_sel_r <= 1'b0;
         bias_r <= 1'b0;
      end else if (wr && hit_clk) begin
         ext_sel_r <= wb_dat_in[rsm_pkg::CK_EXT];
         bias_r <= wb_dat_in[rsm_pkg::CK_BIAS];
      end
   end

   // Operating mode
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         mode_r <= rsm_pkg::MODE_ACTIVE;
      end else if (src) begin
         mode_r <= rsm_pkg::MODE_ACTIVE;
      end else begin
         case (mode_r)
            rsm_pkg::MODE_ACTIVE: begin
               if (sleep_go) begin
                  mode_r <= rsm_pkg::MODE_SLEEP;
               end else if (halt_in) begin
                  mode_r <= rsm_pkg::MODE_STANDBY;
               end
            end
            rsm_pkg::MODE_STANDBY: begin
               if (wake_req_in) begin
                  mode_r <= rsm_pkg::MODE_ACTIVE;
               end
            end
            rsm_pkg::MODE_SLEEP: begin
               mode_r <= rsm_pkg::MODE_SLEEP;
            end
            default: begin
               mode_r <= rsm_pkg::MODE_ACTIVE;
            end
         endcase
      end
   end

   // Stretch so every reset lasts long enough for the core
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         stretch_r <= '0;
      end else if (src) begin
         stretch_r <= SC_W'(RST_STRETCH);
      end else if (stretch_r != '0) begin
         stretch_r <= stretch_r - SC_W'(1);
      end
   end

   // Core restarts at address zero whenever system reset is high
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rst_out <= '1;
      end else begin
         rst_out.cold <= 1'b0;
         rst_out.system <= src || (stretch_r != '0);
         rst_out.pconf <= (src || (stretch_r != '0)) &&
                          ctrl_r.port_cfg_reset_enable;
         rst_out.sleep <= asleep;
      end
   end

   // Port A wake resets the core, so the next instruction must be harmless
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         cpu_halt_out <= 1'b1;
         clk_run_out <= 1'b1;
         rc_osc_en_out <= 1'b1;
         xtal_en_out <= 1'b0;
         rc_bias_out <= 1'b0;
      end else begin
         cpu_halt_out <= (mode_r != rsm_pkg::MODE_ACTIVE);
         clk_run_out <= !asleep;
         rc_osc_en_out <= !asleep;
         xtal_en_out <= ext_sel_r && !asleep;
         rc_bias_out <= bias_r;
      end
   end

   always_comb begin
      rd_nxt = '0;
      if (hit_ctrl) begin
         rd_nxt[rsm_pkg::SC_UNLOCK:rsm_pkg::SC_WD] = ctrl_r;
      end else if (hit_cause) begin
         rd_nxt[rsm_pkg::RC_FLAG_LSB +: rsm_pkg::FL_W] = flags_r;
      end else if (hit_wd) begin
         rd_nxt[rsm_pkg::WD_W-1:0] = wd_count;
      end else if (hit_clk) begin
         rd_nxt[rsm_pkg::CK_EXT] = ext_sel_r;
         rd_nxt[rsm_pkg::CK_BIAS] = bias_r;
      end
   end

   // Unmapped addresses still acknowledge, reading zero
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= '0;
      end else begin
         wb_ack_out <= acc;
         wb_dat_out <= acc ? rd_nxt : '0;
      end
   end

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_unlock_set;
      ctrl_r.sleep_unlock && mode_r == rsm_pkg::MODE_ACTIVE;
   endsequence

   sequence s_sleep_write;
      wr && hit_cause && wb_dat_in[rsm_pkg::RC_SLEEP] && !src;
   endsequence

   property p_sleep_enter;
      s_unlock_set and s_sleep_write |=> asleep ##1 rst_out.sleep && !clk_run_out;
   endproperty
   a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

   property p_sleep_locked;
      !ctrl_r.sleep_unlock && mode_r != rsm_pkg::MODE_SLEEP |=> !asleep;
   endproperty
   a_sleep_locked: assert property (p_sleep_locked) else $error("sleep without unlock");

   property p_sleep_wake;
      asleep && !pin_s_r && !combo_s_r |=> asleep;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("sleep left without wake");

   property p_wd_sticky;
      ctrl_r.watchdog_reset_enable |=> ctrl_r.watchdog_reset_enable;
   endproperty
   a_wd_sticky: assert property (p_wd_sticky) else $error("watchdog enable dropped");

   property p_wd_reset;
      wd_fire && !asleep |=> flags_r[rsm_pkg::FL_WD] ##0 rst_out.system [*4];
   endproperty
   a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset missing");

   property p_pconf;
      rst_out.pconf |-> rst_out.system && ($past(ctrl_r.port_cfg_reset_enable) || rst_out.cold);
   endproperty
   a_pconf: assert property (p_pconf) else $error("port config reset unqualified");

   property p_ctrl_low;
      wb_ack_out && $past(hit_ctrl) |-> wb_dat_out[3:0] == 4'h0;
   endproperty
   a_ctrl_low: assert property (p_ctrl_low) else $error("unused bits nonzero");

   property p_cause_read;
      wb_ack_out && $past(hit_cause) |-> wb_dat_out[7] == 1'b0 && wb_dat_out[6] == 1'b0
                                         && wb_dat_out[0] == 1'b0;
   endproperty
   a_cause_read: assert property (p_cause_read) else $error("cause reserved bits set");

   property p_pin_flag;
      pin_s_r |=> flags_r[rsm_pkg::FL_PIN] && rst_out.system;
   endproperty
   a_pin_flag: assert property (p_pin_flag) else $error("pin cause not flagged");

   property p_halt;
      mode_r == rsm_pkg::MODE_ACTIVE && halt_in && !sleep_go && !src
         |=> mode_r == rsm_pkg::MODE_STANDBY ##1 cpu_halt_out && clk_run_out;
   endproperty
   a_halt: assert property (p_halt) else $error("halt did not stop core");

   property p_ack_once;
      wb_ack_out |=> !wb_ack_out;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

endmodule

`default_nettype wire

//--- hdl/rsm_pkg.sv
package rsm_pkg;

   localparam int ADR_W = 4;
   localparam int DAT_W = 32;

   // Byte addresses of the word-wide registers
   localparam logic [ADR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADR_W-1:0] OFS_CAUSE = 4'h4;
   localparam logic [ADR_W-1:0] OFS_WD = 4'h8;
   localparam logic [ADR_W-1:0] OFS_CLK = 4'hc;

   // system_control fields
   localparam int SC_UNLOCK = 7;
   localparam int SC_PCFG = 6;
   localparam int SC_BAD = 5;
   localparam int SC_WD = 4;

   // reset_cause fields, flags occupy bits 5..1
   localparam int RC_SLEEP = 7;
   localparam int RC_FLAG_LSB = 1;
   localparam int FL_W = 5;
   localparam int FL_BAD = 4;
   localparam int FL_WD = 3;
   localparam int FL_PORT = 2;
   localparam int FL_PIN = 1;
   localparam int FL_PIN_SLP = 0;

   // clock_keep fields
   localparam int CK_EXT = 0;
   localparam int CK_BIAS = 1;

   localparam int WD_W = 4;
   localparam logic [WD_W-1:0] WD_KEY_ARM = 4'ha;
   localparam logic [WD_W-1:0] WD_KEY_FIRE = 4'h3;
   localparam logic [WD_W-1:0] WD_LIMIT = 4'h8;

   localparam int RST_STRETCH = 4;

   typedef enum logic [2:0] {
      MODE_ACTIVE = 3'b001,
      MODE_STANDBY = 3'b010,
      MODE_SLEEP = 3'b100
   } rsm_mode_e;

   typedef struct packed {
      logic cold;
      logic system;
      logic pconf;
      logic sleep;
   } rsm_rst_s;

   typedef struct packed {
      logic sleep_unlock;
      logic port_cfg_reset_enable;
      logic bad_access_reset_enable;
      logic watchdog_reset_enable;
   } rsm_ctrl_s;

endpackage

//--- hdl/rsm_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

module rsm_watchdog #(
   parameter int CNT_W = 4
) (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic key_wr_in,
   input wire logic [rsm_pkg::WD_W-1:0] key_in,
   input wire logic tick_in,
   input wire logic enable_in,
   input wire logic restart_in,
   output logic [CNT_W-1:0] count_out,
   output logic fire_out
);

   generate
      if (CNT_W < rsm_pkg::WD_W) begin : g_bad_width
         $error("rsm_watchdog: CNT_W too small for limit");
      end
   endgenerate

   logic [rsm_pkg::WD_W-1:0] watchdog_key_r;
   logic clear;

   // Only a fire key right after an arm key clears
   assign clear = key_wr_in && (watchdog_key_r == rsm_pkg::WD_KEY_ARM) &&
                  (key_in == rsm_pkg::WD_KEY_FIRE);

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         watchdog_key_r <= '0;
      end else if (key_wr_in) begin
         watchdog_key_r <= key_in;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in || restart_in || clear) begin
         count_out <= '0;
      end else if (tick_in && (count_out < CNT_W'(rsm_pkg::WD_LIMIT))) begin
         count_out <= count_out + CNT_W'(1);
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         fire_out <= 1'b0;
      end else begin
         fire_out <= enable_in && (count_out == CNT_W'(rsm_pkg::WD_LIMIT)) &&
                     !restart_in && !fire_out;
      end
   end

endmodule

`default_nettype wire

//--- tb/rsm_far_end.sv
`timescale 1ns/1ps
`default_nettype none

module rsm_far_end (
   input wire logic clock_in,
   output logic reset_pin_out,
   output logic port_combo_out,
   output logic halt_out,
   output logic wake_req_out,
   output logic wd_tick_out,
   output logic bad_access_out
);
   logic [5:0] lv;

   assign reset_pin_out = lv[5];
   assign port_combo_out = lv[4];
   assign halt_out = lv[3];
   assign wake_req_out = lv[2];
   assign wd_tick_out = lv[1];
   assign bad_access_out = lv[0];

   initial lv = 6'h00;

   // n pulses of len cycles; gap of at least one keeps each edge single-driven
   task automatic drive(input int b, input int len, input int n, input int gap);
      repeat (n) begin
         lv[b] <= 1'b1;
         repeat (len) @(posedge clock_in);
         lv[b] <= 1'b0;
         repeat (gap) @(posedge clock_in);
      end
   endtask
endmodule

`default_nettype wire

//--- tb/rsm_reset_sleep_tb.sv
`timescale 1ns/1ps
`default_nettype none

module rsm_reset_sleep_tb;
   logic clock_in, sys_rst_in, cyc, stb, we, ack;
   logic [rsm_pkg::ADR_W-1:0] adr;
   logic [3:0] sel;
   logic [rsm_pkg::DAT_W-1:0] wdat, rdat, q;
   logic cpu_halt, clk_run, rc_en, xtal_en, bias, pin, combo, halt, wake, tick, bad;
   rsm_pkg::rsm_rst_s rs;
   int mismatches, cmp_count;

   rsm_reset_sleep dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .reset_pin_in(pin), .port_combo_in(combo), .bad_access_in(bad),
      .halt_in(halt), .wake_req_in(wake), .wd_tick_in(tick), .rst_out(rs), .cpu_halt_out(cpu_halt),
      .clk_run_out(clk_run), .rc_osc_en_out(rc_en), .xtal_en_out(xtal_en), .rc_bias_out(bias));

   rsm_far_end far (.clock_in(clock_in), .reset_pin_out(pin), .port_combo_out(combo),
      .halt_out(halt), .wake_req_out(wake), .wd_tick_out(tick), .bad_access_out(bad));

   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Request held until ack is sampled; one idle cycle follows
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hf;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clock_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         mismatches++;
         test_done();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clock_in);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return rs.system;
         1: return rs.sleep;
         default: return cpu_halt;
      endcase
   endfunction

   task automatic wt(input int s, input logic v);
      int n;
      n = 0;
      while (pick(s) !== v && n < 200) begin
         @(posedge clock_in);
         n++;
      end
      chk(pick(s), v);
      if (pick(s) !== v) test_done();
   endtask

   // Full system reset pass: rise, then release
   task automatic sysrst();
      wt(0, 1'b1);
      wt(1, 1'b0);
      wt(0, 1'b0);
      @(posedge clock_in);
   endtask

   initial begin
      sys_rst_in = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      sel = 4'hf;
      wdat = 32'h0000_0000;
      mismatches = 0;
      cmp_count = 0;
      repeat (10) @(posedge clock_in);
      chk(rs, 4'hf);
      chk({cpu_halt, rc_en, xtal_en}, 3'h6);
      sys_rst_in <= 1'b0;
      @(posedge clock_in);
      rd(rsm_pkg::OFS_CTRL, 8'h00);
      chk({rs, cpu_halt}, 5'h00);
      rd(rsm_pkg::OFS_CAUSE, 8'h00);
      rd(rsm_pkg::OFS_WD, 8'h00);
      rd(4'h1, 8'h00);
      chk(rs.system, 1'h0);
      bus(1'b1, rsm_pkg::OFS_CTRL, 32'h0000_000f);
      rd(rsm_pkg::OFS_CTRL, 8'h00);
      bus(1'b1, rsm_pkg::OFS_CTRL, 32'h0000_00ff);
      rd(rsm_pkg::OFS_CTRL, 8'hf0);
      bus(1'b1, rsm_pkg::OFS_CTRL, 32'h0000_0000);
      rd(rsm_pkg::OFS_CTRL, 8'h10);
      // Sleep request while still locked must do nothing
      bus(1'b1, rsm_pkg::OFS_CAUSE, 32'h0000_0080);
      chk(rs.sleep, 1'h0);
      rd(rsm_pkg::OFS_CAUSE, 8'h00);
      far.drive(1, 1, 3, 1);
      rd(rsm_pkg::OFS_WD, 8'h03);
      bus(1'b1, rsm_pkg::OFS_WD, 32'h0000_000a);
      bus(1'b1, rsm_pkg::OFS_WD, 32'h0000_0005);
      bus(1'b1, rsm_pkg::OFS_WD, 32'h0000_0003);
      rd(rsm_pkg::OFS_WD, 8'h03);
      bus(1'b1, rsm_pkg::OFS_WD, 32'h0000_000a);
      bus(1'b1, rsm_pkg::OFS_WD, 32'h0000_0003);
      rd(rsm_pkg::OFS_WD, 8'h00);
      far.drive(1, 1, 8, 1);
      wt(0, 1'b1);
      @(posedge clock_in);
      chk(rs.pconf, 1'h0);
      sysrst();
      rd(rsm_pkg::OFS_CAUSE, 8'h10);
      rd(rsm_pkg::OFS_CAUSE, 8'h00);
      rd(rsm_pkg::OFS_WD, 8'h00);
      rd(rsm_pkg::OFS_CTRL, 8'h10);
      bus(1'b1, rsm_pkg::OFS_CTRL, 32'h0000_0070);
      rd(4'h1, 8'h00);
      wt(0, 1'b1);
      @(posedge clock_in);
      chk(rs.pconf, 1'h1);
      sysrst();
      far.drive(5, 3, 1, 1);
      sysrst();
      rd(rsm_pkg::OFS_CAUSE, 8'h24);
      far.drive(0, 1, 1, 1);
      sysrst();
      bus(1'b1, rsm_pkg::OFS_CAUSE, 32'h0000_0000);
      rd(rsm_pkg::OFS_CAUSE, 8'h00);
      rd(rsm_pkg::OFS_CTRL, 8'h70);
      far.drive(3, 1, 1, 1);
      wt(2, 1'b1);
      chk(clk_run, 1'h1);
      far.drive(2, 3, 1, 1);
      wt(2, 1'b0);
      bus(1'b1, rsm_pkg::OFS_CLK, 32'h0000_0003);
      chk({xtal_en, bias}, 2'h3);
      bus(1'b1, rsm_pkg::OFS_CTRL, 32'h0000_00f0);
      // Idle cycle after the sleep write stands in for the no-op
      bus(1'b1, rsm_pkg::OFS_CAUSE, 32'h0000_0080);
      wt(1, 1'b1);
      chk({clk_run, rc_en, xtal_en}, 3'h0);
      far.drive(4, 3, 1, 1);
      sysrst();
      rd(rsm_pkg::OFS_CAUSE, 8'h08);
      rd(rsm_pkg::OFS_CLK, 8'h03);
      rd(rsm_pkg::OFS_CTRL, 8'hf0);
      bus(1'b1, rsm_pkg::OFS_CAUSE, 32'h0000_0080);
      wt(1, 1'b1);
      far.drive(5, 3, 1, 1);
      sysrst();
      rd(rsm_pkg::OFS_CAUSE, 8'h06);
      test_done();
   end
endmodule

`default_nettype wire
